// file: hw/etas_map.svh
// Constants for the edge timed asynchronous serial port
// Notes on behaviour
// - Idle line stays high on both sides
// - Each character starts with one low bit
// - Data bits go least significant first
// - At least one high stop bit between characters
// - Idle gaps of any length are accepted
// - Eight data bits usual, seven or nine allowed
// - Top data bit may carry parity
// - Master transmit rate within half a percent
// - Receiver tolerates two percent rate error
// - Minimal receiver aligns on start edge only
// - Break is low longer than data plus one
// - Frame break lasts at least thirteen bits
// - Timestamp edges, rebuild bits from differences
// - Same level as before means glitch, dropped
// - Idle edge starts character only if low
// - Active edge converts interval into bit count
// - Rising edge shifts in zero bits
// - Falling edge shifts ones, checks completion each
// - Each run may be half bit off
// - Edge handling may lag almost one bit
// - Tick past stop end finishes pending character
// - Tick keeps running while reception active
// - Transmit bits timed by exact bit ticks
// - Data bits configurable from one to fourteen
// - Tick stops when everything idle
`ifndef ETAS_MAP_SVH
`define ETAS_MAP_SVH
`define ETAS_CLK_HZ 200000000
`define ETAS_BAUD 19200
`define ETAS_BIT_CYC (`ETAS_CLK_HZ / `ETAS_BAUD)
`define ETAS_TW 24
`define ETAS_SHW 16
`define ETAS_DW 14
`define ETAS_CW 5
`define ETAS_BRK_FRAME 16'h4000
`define ETAS_BRK_LEN 5'h0F
`define ETAS_IDLE_LVL 1'b1
`define ETAS_FIFO_DEPTH 16
`define ETAS_DEF_BITS 4'h8
`endif

// file: hw/etas_pkg.sv
// Types for the edge timed asynchronous serial port
`include "etas_map.svh"
package etas_pkg;
   typedef enum logic [0:0] {
      RX_EDGE = 1'b0,
      RX_RUN = 1'b1
   } etas_rx_t;
   typedef struct packed {
      logic [`ETAS_TW-1:0] tmr;
      logic [`ETAS_TW-1:0] oc;
      logic tick_en;
      logic tx_line;
      logic [`ETAS_SHW-1:0] tx_sh;
      logic [`ETAS_CW-1:0] tx_cnt;
      logic txb_full;
      logic [`ETAS_DW:0] txb;
      logic rx_prev;
      logic cap_pend;
      logic [`ETAS_TW-1:0] cap_time;
      logic rx_lvl;
      logic rx_act;
      etas_rx_t rx_st;
      logic [`ETAS_TW-1:0] rx_last_t;
      logic [`ETAS_TW-1:0] rx_start_t;
      logic [`ETAS_SHW-1:0] rx_sh;
      logic [`ETAS_CW-1:0] rx_cnt;
      logic [`ETAS_TW-1:0] rem;
      logic rem_one;
      logic restart;
      logic [`ETAS_DW-1:0] rx_buf;
      logic rx_valid;
      logic rx_overrun;
      logic rx_break;
      logic rx_ferr;
   } etas_state_t;
endpackage

// file: hw/etas_serial.sv
// Edge timed asynchronous serial port with its transmit FIFO
`timescale 1ns/1ps
`default_nettype none
`include "etas_map.svh"

module etas_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = `ETAS_FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;

   // Full when pointers differ only in the wrap bit
   assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_valid = (wr_q != rd_q);
   assign out_data = mem_q[rd_q[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule

module etas_serial #(
   parameter int BIT_CYCLES = `ETAS_BIT_CYC,
   parameter int FIFO_DEPTH = `ETAS_FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] cfg_bits,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [`ETAS_DW-1:0] tx_data,
   input wire logic tx_break,
   output logic tx_line,
   output logic tx_empty,
   input wire logic rx_line,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [`ETAS_DW-1:0] rx_data,
   output logic rx_overrun,
   output logic rx_break,
   output logic rx_frame_err,
   output logic rx_busy
);
   localparam logic [`ETAS_TW-1:0] BIT_T = `ETAS_TW'(BIT_CYCLES);
   localparam logic [`ETAS_TW-1:0] HALF_T = `ETAS_TW'(BIT_CYCLES / 2);

   etas_pkg::etas_state_t q;
   etas_pkg::etas_state_t d;
   logic f_valid;
   logic f_ready;
   logic [`ETAS_DW:0] f_data;

   // Back-pressure: the FIFO drains only into an empty transmit buffer
   etas_fifo #(
      .WIDTH(`ETAS_DW + 1),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data({tx_break, tx_data}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   assign f_ready = !q.txb_full;
   assign tx_line = q.tx_line;
   assign tx_empty = !q.txb_full;
   assign rx_valid = q.rx_valid;
   assign rx_data = q.rx_buf;
   assign rx_overrun = q.rx_overrun;
   assign rx_break = q.rx_break;
   assign rx_frame_err = q.rx_ferr;
   assign rx_busy = q.rx_act;

   always_comb begin
      logic tick;
      logic [3:0] n;
      logic [`ETAS_CW-1:0] need;
      logic [`ETAS_TW-1:0] end_t;
      logic [`ETAS_SHW-1:0] src;
      logic [`ETAS_CW-1:0] cnt;
      logic [`ETAS_DW-1:0] dmask;
      logic [`ETAS_DW-1:0] word;
      logic [`ETAS_SHW-1:0] nsh;
      logic [`ETAS_CW-1:0] ncnt;
      d = q;
      n = (cfg_bits == 4'h0) ? 4'h1 : cfg_bits;
      need = `ETAS_CW'(n) + `ETAS_CW'(2);
      end_t = `ETAS_TW'((32'(n) + 32'd2) * 32'(BIT_CYCLES));
      dmask = `ETAS_DW'((16'h0001 << n) - 16'h0001);
      src = q.tx_sh;
      cnt = q.tx_cnt;
      word = '0;
      nsh = q.rx_sh;
      ncnt = q.rx_cnt;
      d.rx_overrun = 1'b0;
      d.rx_break = 1'b0;
      d.rx_ferr = 1'b0;

      // Free-running timer stamps every edge and paces every bit
      d.tmr = q.tmr + 1'b1;
      tick = q.tick_en && (q.tmr == q.oc);

      if (f_valid && !q.txb_full) begin
         d.txb_full = 1'b1;
         d.txb = f_data;
      end

      // Tick restarts one bit from now, so the first bit begins a bit later
      if (!q.tick_en && (q.txb_full || q.tx_cnt != '0 || q.rx_act)) begin
         d.tick_en = 1'b1;
         d.oc = q.tmr + BIT_T;
      end

      if (tick) begin
         // Adding to the old compare keeps bits exact to the cycle
         d.oc = q.oc + BIT_T;
         if (q.tx_cnt == '0 && q.txb_full) begin
            d.txb_full = 1'b0;
            if (q.txb[`ETAS_DW]) begin
               src = `ETAS_BRK_FRAME;
               cnt = `ETAS_BRK_LEN;
            end else begin
               src = {1'b0, q.txb[`ETAS_DW-1:0] & dmask, 1'b0};
               src = src | (`ETAS_SHW'(1) << (n + 4'h1));
               cnt = need;
            end
         end
         if (cnt != '0) begin
            d.tx_line = src[0];
            d.tx_sh = src >> 1;
            d.tx_cnt = cnt - 1'b1;
         end else begin
            d.tx_line = `ETAS_IDLE_LVL;
            d.tx_sh = '0;
         end
      end

      // A newer edge beats the clear of the pending flag
      d.rx_prev = rx_line;

      if (q.rx_valid && rx_ready) begin
         d.rx_valid = 1'b0;
      end

      unique case (q.rx_st)
         etas_pkg::RX_EDGE: begin
            if (q.cap_pend) begin
               d.cap_pend = 1'b0;
               if (rx_line == q.rx_lvl) begin
                  d.cap_pend = 1'b0;
               end else begin
                  d.rx_lvl = rx_line;
                  if (!q.rx_act) begin
                     if (!rx_line) begin
                        d.rx_act = 1'b1;
                        d.rx_last_t = q.cap_time;
                        d.rx_start_t = q.cap_time;
                        d.rx_cnt = '0;
                        d.rx_sh = '0;
                     end
                  end else begin
                     // Stamped time, not handling time, so latency is harmless
                     d.rem = q.cap_time - q.rx_last_t;
                     d.rem_one = !rx_line;
                     d.restart = !rx_line;
                     d.rx_last_t = q.cap_time;
                     d.rx_st = etas_pkg::RX_RUN;
                  end
               end
            end else if (tick && q.rx_act && q.rx_lvl) begin
               // Line high since last edge: remaining bits are all ones
               if (q.tmr - q.rx_start_t >= end_t) begin
                  d.rem = '1;
                  d.rem_one = 1'b1;
                  d.restart = 1'b0;
                  d.rx_st = etas_pkg::RX_RUN;
               end
            end
         end
         etas_pkg::RX_RUN: begin
            // Rounding at half a bit absorbs rate error per run
            if (q.rem >= HALF_T) begin
               nsh = {q.rem_one, q.rx_sh[`ETAS_SHW-1:1]};
               ncnt = q.rx_cnt + 1'b1;
               d.rx_sh = nsh;
               d.rx_cnt = ncnt;
               d.rem = (q.rem >= BIT_T) ? (q.rem - BIT_T) : '0;
               if (ncnt == need) begin
                  // One bit at a time so an early next start is caught
                  word = `ETAS_DW'(nsh >> (4'hF - n)) & dmask;
                  if (nsh[`ETAS_SHW-1]) begin
                     d.rx_overrun = q.rx_valid && !rx_ready;
                     d.rx_buf = word;
                     d.rx_valid = 1'b1;
                  end else if (word == '0) begin
                     d.rx_break = 1'b1;
                  end else begin
                     d.rx_ferr = 1'b1;
                  end
                  d.rx_st = etas_pkg::RX_EDGE;
                  d.rx_act = q.restart;
                  d.rx_start_t = q.rx_last_t;
                  d.rx_cnt = '0;
                  d.rx_sh = '0;
               end
            end else begin
               d.rx_st = etas_pkg::RX_EDGE;
            end
         end
      endcase

      if (rx_line != q.rx_prev) begin
         d.cap_pend = 1'b1;
         d.cap_time = q.tmr;
      end

      if (tick && d.tx_cnt == '0 && !d.txb_full && !d.rx_act) begin
         d.tick_en = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         q <= '0;
         q.tx_line <= `ETAS_IDLE_LVL;
         q.rx_prev <= `ETAS_IDLE_LVL;
         q.rx_lvl <= `ETAS_IDLE_LVL;
      end else begin
         q <= d;
      end
   end

   // Accuracy is the clock's; integer bit period keeps error well under 0.5%
endmodule
`default_nettype wire

// file: dv/etas_serial_asserts.sv
// Port assertions for the serial port
`timescale 1ns/1ps
`default_nettype none
`include "etas_map.svh"
module etas_serial_asserts #(
   parameter int BIT_CYCLES = 16,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic tx_line,
   input wire logic tx_empty,
   input wire logic rx_line,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic [`ETAS_DW-1:0] rx_data,
   input wire logic rx_overrun,
   input wire logic rx_break,
   input wire logic rx_frame_err,
   input wire logic rx_busy
);
   // Long runs are counted, a repetition would unroll too far
   int lo_q;
   int hi_q;
   logic pl;
   assign pl = rx_overrun | rx_break | rx_frame_err;
   always_ff @(posedge clock) begin
      lo_q <= (rst || tx_line) ? 0 : lo_q + 1;
      hi_q <= (rst || !rx_busy || !rx_line) ? 0 : hi_q + 1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Start must stay low for a second sample, a one-cycle dip is a glitch
   sequence s_go; $fell(rx_line) && !rx_busy ##1 !rx_line; endsequence
   sequence s_put; tx_valid && tx_ready && tx_empty; endsequence
   property p_rst;
      disable iff (1'b0) rst |=> tx_line && tx_empty && !rx_busy && !rx_valid;
   endproperty
   property p_low; $rose(tx_line) |-> lo_q % BIT_CYCLES == 0 && lo_q <= 15 * BIT_CYCLES; endproperty
   property p_empty; s_put |-> ##[1:3] !tx_empty; endproperty
   property p_go; s_go |-> ##[0:3] rx_busy; endproperty
   property p_tmo; hi_q <= 18 * BIT_CYCLES; endproperty
   property p_hold; rx_valid && !rx_ready |=> rx_valid && ($stable(rx_data) || rx_overrun); endproperty
   property p_pls; pl |=> !pl; endproperty
   property p_exc; rx_break |-> !rx_frame_err; endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   a_low: assert property (p_low) else $error("low run length");
   a_empty: assert property (p_empty) else $error("buffer not loaded");
   a_go: assert property (p_go) else $error("start not taken");
   a_tmo: assert property (p_tmo) else $error("no timeout");
   a_hold: assert property (p_hold) else $error("rx data dropped");
   a_pls: assert property (p_pls) else $error("long pulse");
   a_exc: assert property (p_exc) else $error("break and frame");
endmodule
bind etas_serial etas_serial_asserts #(.BIT_CYCLES(BIT_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
   .clock(clock), .rst(rst), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_line(tx_line),
   .tx_empty(tx_empty), .rx_line(rx_line), .rx_valid(rx_valid), .rx_ready(rx_ready),
   .rx_data(rx_data), .rx_overrun(rx_overrun), .rx_break(rx_break),
   .rx_frame_err(rx_frame_err), .rx_busy(rx_busy));
`default_nettype wire

// file: dv/etas_node.sv
// Far node: drives the receive line and decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module etas_node #(
   parameter int BIT_CYCLES = 16
) (
   input wire logic clock,
   input wire logic tx_line,
   output logic rx_line
);
   int nbits = 8;
   logic [14:0] got[$];
   initial rx_line = 1'b1;
   task automatic hold(input logic v, input int c);
      rx_line = v;
      repeat (c) @(posedge clock);
      #1;
   endtask
   // Bit length c plays a fast or slow sender
   task automatic send(input logic [13:0] d, input int n, input int c, input logic stp);
      hold(1'b0, c);
      for (int i = 0; i < n; i++) begin
         hold(d[i], c);
      end
      hold(stp, c);
   endtask
   task automatic brk(input int n, input int c);
      hold(1'b0, n * c);
      hold(1'b1, c);
   endtask
   always begin
      logic [14:0] w;
      @(negedge tx_line);
      w = '0;
      repeat (BIT_CYCLES / 2) @(posedge clock);
      for (int i = 0; i <= nbits; i++) begin
         repeat (BIT_CYCLES) @(posedge clock);
         w[i] = tx_line;
      end
      got.push_back(w);
      wait (tx_line === 1'b1);
   end
endmodule
`default_nettype wire

// file: dv/etas_serial_tb.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
`include "etas_map.svh"
module etas_serial_tb;
   localparam int BIT = 50;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [3:0] cfg_bits = 4'h8;
   logic tx_valid = 1'b0;
   logic [`ETAS_DW-1:0] tx_data = '0;
   logic tx_break = 1'b0;
   logic rx_ready = 1'b1;
   logic tx_ready, tx_line, tx_empty, rx_line, rx_valid, rx_busy;
   logic rx_overrun, rx_break, rx_frame_err;
   logic [`ETAS_DW-1:0] rx_data;
   logic full_seen = 1'b0;
   logic [16:0] lf = 17'h18518;
   logic [14:0] exq[$];
   logic [14:0] rq[$];
   int lens[5] = '{1, 7, 8, 9, 14};
   int n_mismatch = 0;
   int n_tests = 0;
   int n_ovr = 0;
   int n_brk = 0;
   int n_ferr = 0;
   always #2.5 clock = ~clock;
   etas_serial #(.BIT_CYCLES(BIT), .FIFO_DEPTH(16)) DUT (
      .clock(clock), .rst(rst), .cfg_bits(cfg_bits), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .tx_break(tx_break), .tx_line(tx_line), .tx_empty(tx_empty),
      .rx_line(rx_line), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .rx_overrun(rx_overrun), .rx_break(rx_break), .rx_frame_err(rx_frame_err),
      .rx_busy(rx_busy));
   etas_node #(.BIT_CYCLES(BIT)) node (.clock(clock), .tx_line(tx_line), .rx_line(rx_line));
   always @(posedge clock) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) rq.push_back(15'(rx_data));
      if (rx_overrun === 1'b1) n_ovr++;
      if (rx_break === 1'b1) n_brk++;
      if (rx_frame_err === 1'b1) n_ferr++;
      if (tx_ready === 1'b0) full_seen = 1'b1;
   end
   function automatic logic [13:0] rnd();
      lf = {lf[15:0], lf[16] ^ lf[13]};
      return lf[13:0];
   endfunction
   function automatic logic [14:0] frm(input logic [13:0] d, input int n, input logic stp);
      logic [14:0] m;
      m = (15'h1 << n) - 15'h1;
      return (15'(d) & m) | (15'(stp) << n);
   endfunction
   task automatic check(input logic [14:0] seen, input logic [14:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic step(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask
   task automatic push(input logic [13:0] d, input logic b, input int n);
      tx_valid = 1'b1;
      tx_data = d;
      tx_break = b;
      exq.push_back(b ? 15'h0 : frm(d, n, 1'b1));
      while (tx_ready !== 1'b1) step(1);
      step(1);
   endtask
   task automatic drain(input logic rx);
      repeat (400 * BIT) if ((rx ? rq.size() : node.got.size()) < exq.size()) step(1);
      while (exq.size() > 0) begin
         check(rx ? rq.pop_front() : node.got.pop_front(), exq.pop_front());
      end
   endtask
   initial begin
      logic [13:0] d;
      int t;
      step(16);
      rst = 1'b0;
      push(rnd(), 1'b0, 8);
      tx_valid = 1'b0;
      t = 0;
      while (tx_line !== 1'b0 && t < 4 * BIT) begin
         step(1);
         t++;
      end
      check(15'(t >= BIT && t <= BIT + 4), 15'h1);
      foreach (lens[i]) begin
         drain(1'b0);
         cfg_bits = 4'(lens[i]);
         node.nbits = lens[i];
         repeat (lens[i] == 8 ? 20 : 3) push(rnd(), 1'b0, lens[i]);
         tx_valid = 1'b0;
      end
      drain(1'b0);
      check(15'(full_seen), 15'h1);
      check(15'(tx_empty), 15'h1);
      cfg_bits = 4'h8;
      node.nbits = 8;
      push(14'h0, 1'b1, 8);
      push(rnd(), 1'b0, 8);
      tx_valid = 1'b0;
      drain(1'b0);
      foreach (lens[i]) begin
         cfg_bits = 4'(lens[i]);
         repeat (3) begin
            d = rnd();
            exq.push_back(frm(d, lens[i], 1'b0));
            node.send(d, lens[i], BIT - 1 + int'(d % 3), 1'b1);
            step(1 + int'(d[5:0]) % 37);
         end
         drain(1'b1);
      end
      // Byte characters from here on; the loop left the longest length set
      cfg_bits = 4'h8;
      rx_ready = 1'b0;
      node.send(14'h00A5, 8, BIT, 1'b1);
      node.send(14'h003C, 8, BIT, 1'b1);
      repeat (4 * BIT) if (n_ovr == 0) step(1);
      check(15'(n_ovr), 15'h1);
      check(15'(rx_data), 15'h003C);
      rx_ready = 1'b1;
      node.hold(1'b0, 1);
      node.hold(1'b1, 2 * BIT);
      check(15'(rx_busy), 15'h0);
      node.brk(13, BIT);
      node.send(14'h005A, 8, BIT, 1'b0);
      node.hold(1'b1, 3 * BIT);
      check(15'(n_brk), 15'h1);
      check(15'(n_ferr), 15'h1);
      wrap_up();
   end
   initial begin
      repeat (90000) @(posedge clock);
      n_mismatch++;
      wrap_up();
   end
endmodule
`default_nettype wire
